// ---- abu_address_breakpoint_unit.sv ----
/*
 * Address breakpoint unit: break address registers, status/control
 * register, match logic and the break sequence handed to the CPU.
 * Assumes a synchronous internal bus on clk with one-cycle strobes,
 * and a CPU that reports its fetch address, the last cycle of each
 * instruction, RETURN_FROM_INTERRUPT_OPCODE execution and the wait, stop and monitor modes.
 */
// What this block does
// R01: Signal a breakpoint when CPU program address equals the break address.
// R02: CPU loads the SOFTWARE_INTERRUPT_OPCODE opcode once the current instruction completes.
// R03: Vector is FFFC/FFFD in user mode, FEFC/FEFD in monitor mode.
// R04: A match on an instruction's last cycle starts the break at once.
// R05: Writing one to the active bit raises a break like a match.
// R06: Match sets the active bit; reset clears it; software writes zero.
// R07: Enable bit 7 gates address-match breaks; written zero or reset clears.
// R08: RETURN_FROM_INTERRUPT_OPCODE inside the break routine ends the break state.
// R09: Timer counter halts while a break is in progress.
// R10: Watchdog disabled during break when the high test voltage is present.
// R11: Flag-clear-enable decides if break-time accesses may clear status flags.
// R12: Unit works in wait mode; wait-break status records a break wake.
// R13: No matching in stop mode; stop leaves registers unchanged.
// R14: Address registers hold high and low bytes; reset clears both.
// R15: Status/control at FE0B, address high at FE0C, low at FE0D.
// R16: A match counts only while the enable bit is set.
// R17: Address registers read back the last bytes written.
`timescale 1ns/1ps
`include "abu_defs.svh"

module abu_address_breakpoint_unit
	import abu_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [15:0] busAddr,
	input wire logic [7:0] busWrData,
	input wire logic busWr,
	input wire logic busRd,
	output logic [7:0] busRdData_ff,
	input wire logic [15:0] cpuAddr,
	input wire logic cpuFetch,
	input wire logic instrLastCycle,
	input wire logic rtiExec,
	input wire logic monitorMode,
	input wire logic waitMode,
	input wire logic stopMode,
	input wire logic highTestVoltage,
	input wire logic flagClearEnable,
	input wire logic waitBreakClear,
	output logic breakReq_ff,
	output logic forceSwi_ff,
	output logic [15:0] vectorAddr_ff,
	output logic timerHalt_ff,
	output logic watchdogDisable_ff,
	output logic flagClearAllowed_ff,
	output logic waitBreak_ff
);

	// ********************************
	// Declarations
	// ********************************
	logic [7:0] addrHigh_ff;
	logic [7:0] addrLow_ff;
	logic enable_ff;
	logic active_ff;
	abu_state_t state_ff;
	abu_state_t nxt_state;
	logic wrCtrl;
	logic wrHigh;
	logic wrLow;
	logic swBreak;
	logic hwMatch;
	logic trigger;
	logic start;
	logic [7:0] nxt_rdData;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
		hit = (a == target);
	endfunction

	// ********************************
	// Register decode
	// ********************************
	assign wrCtrl = busWr && hit(busAddr, `ABU_STATUS_CONTROL_ADDR); // R15
	assign wrHigh = busWr && hit(busAddr, `ABU_ADDRESS_HIGH_ADDR); // R15
	assign wrLow = busWr && hit(busAddr, `ABU_ADDRESS_LOW_ADDR); // R15
	assign swBreak = wrCtrl && busWrData[`ABU_ACTIVE_BIT]; // R05

	// Stop mode masks the match term itself, so matching is held off even while the fetch address moves
	assign hwMatch = enable_ff && cpuFetch && !stopMode
		&& hit(cpuAddr, {addrHigh_ff, addrLow_ff}); // R01 R13 R16
	assign trigger = hwMatch || swBreak;

	// A trigger on the last cycle goes straight to the SOFTWARE_INTERRUPT_OPCODE load
	assign start = (state_ff != ABU_BREAK) && instrLastCycle
		&& (trigger || state_ff == ABU_PEND); // R02 R04

	// ********************************
	// Break address registers
	// ********************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			addrHigh_ff <= `ABU_ADDRESS_RESET; // R14
			addrLow_ff <= `ABU_ADDRESS_RESET; // R14
		end else begin
			if (wrHigh) begin
				addrHigh_ff <= busWrData; // R17
			end
			if (wrLow) begin
				addrLow_ff <= busWrData; // R17
			end
		end
	end

	// ********************************
	// Enable and active bits
	// ********************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			enable_ff <= 1'b0; // R07
		end else if (wrCtrl) begin
			enable_ff <= busWrData[`ABU_ENABLE_BIT]; // R07
		end
	end

	// A match in the cycle of a clearing write wins, so no hit is lost
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			active_ff <= 1'b0; // R06
		end else if (hwMatch || swBreak) begin
			active_ff <= 1'b1; // R05 R06
		end else if (wrCtrl) begin
			active_ff <= 1'b0; // R06
		end
	end

	// ********************************
	// Break sequence
	// ********************************
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ABU_IDLE: begin
				if (start) begin
					nxt_state = ABU_BREAK;
				end else if (trigger) begin
					nxt_state = ABU_PEND;
				end
			end
			ABU_PEND: begin
				if (start) begin
					nxt_state = ABU_BREAK;
				end
			end
			ABU_BREAK: begin
				if (rtiExec) begin
					nxt_state = ABU_IDLE; // R08
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= ABU_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ********************************
	// CPU side outputs
	// ********************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			breakReq_ff <= 1'b0;
			forceSwi_ff <= 1'b0;
			vectorAddr_ff <= `ABU_USER_VECTOR;
		end else begin
			breakReq_ff <= (nxt_state == ABU_PEND) || start; // R01
			forceSwi_ff <= start; // R02
			if (start) begin
				vectorAddr_ff <= monitorMode ? `ABU_MONITOR_VECTOR
					: `ABU_USER_VECTOR; // R03
			end
		end
	end

	// ********************************
	// Effects on other modules
	// ********************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			timerHalt_ff <= 1'b0;
			watchdogDisable_ff <= 1'b0;
			flagClearAllowed_ff <= 1'b1;
		end else begin
			timerHalt_ff <= (nxt_state == ABU_BREAK); // R09
			watchdogDisable_ff <= (nxt_state == ABU_BREAK) && highTestVoltage; // R10
			flagClearAllowed_ff <= (nxt_state != ABU_BREAK) || flagClearEnable; // R11
		end
	end

	// Set wins over clear so a wake in the clearing cycle is kept
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			waitBreak_ff <= 1'b0;
		end else if (start && waitMode) begin
			waitBreak_ff <= 1'b1; // R12
		end else if (waitBreakClear) begin
			waitBreak_ff <= 1'b0;
		end
	end

	// ********************************
	// Read path
	// ********************************
	always_comb begin
		nxt_rdData = `ABU_READ_IDLE;
		if (hit(busAddr, `ABU_STATUS_CONTROL_ADDR)) begin
			nxt_rdData[`ABU_ENABLE_BIT] = enable_ff;
			nxt_rdData[`ABU_ACTIVE_BIT] = active_ff;
		end else if (hit(busAddr, `ABU_ADDRESS_HIGH_ADDR)) begin
			nxt_rdData = addrHigh_ff; // R17
		end else if (hit(busAddr, `ABU_ADDRESS_LOW_ADDR)) begin
			nxt_rdData = addrLow_ff; // R17
		end
	end

	// Unmapped or idle reads return zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busRdData_ff <= `ABU_READ_IDLE;
		end else begin
			busRdData_ff <= busRd ? nxt_rdData : `ABU_READ_IDLE;
		end
	end

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_match_sets_active: assert property ( // R06
		hwMatch |=> active_ff)
		else $error("address match did not set the active bit");

	chk_active_has_cause: assert property ( // R16
		$rose(active_ff) |-> $past(hwMatch) || $past(swBreak))
		else $error("active bit rose without a match or a write");

	chk_match_raises_req: assert property ( // R01
		(state_ff == ABU_IDLE && hwMatch) |=> breakReq_ff || timerHalt_ff)
		else $error("match did not raise the breakpoint signal");

	chk_swi_at_end: assert property ( // R02
		forceSwi_ff |-> $past(instrLastCycle) && timerHalt_ff)
		else $error("SOFTWARE_INTERRUPT_OPCODE load not at an instruction end");

	chk_immediate_start: assert property ( // R04
		(state_ff == ABU_IDLE && hwMatch && instrLastCycle) |=> forceSwi_ff)
		else $error("last-cycle match did not start at once");

	chk_soft_break: assert property ( // R05
		(state_ff == ABU_IDLE && swBreak && !instrLastCycle)
		|=> breakReq_ff && active_ff)
		else $error("write of the active bit did not raise a break");

	chk_vector_select: assert property ( // R03
		forceSwi_ff |-> vectorAddr_ff == ($past(monitorMode)
			? `ABU_MONITOR_VECTOR : `ABU_USER_VECTOR))
		else $error("wrong break vector");

	chk_rti_ends: assert property ( // R08
		(state_ff == ABU_BREAK && rtiExec) |=> state_ff == ABU_IDLE && !timerHalt_ff)
		else $error("RETURN_FROM_INTERRUPT_OPCODE did not end the break");

	chk_timer_halt: assert property ( // R09
		(state_ff == ABU_BREAK) == timerHalt_ff)
		else $error("timer halt differs from break state");

	chk_watchdog_off: assert property ( // R10
		watchdogDisable_ff |-> timerHalt_ff && $past(highTestVoltage))
		else $error("watchdog disabled outside a break");

	chk_flag_guard: assert property ( // R11
		(state_ff == ABU_BREAK && !$past(flagClearEnable)) |-> !flagClearAllowed_ff)
		else $error("flag clearing allowed in break without enable");

	chk_wait_break: assert property ( // R12
		(forceSwi_ff && $past(waitMode)) |-> waitBreak_ff)
		else $error("wait-break status not set");

	chk_stop_quiet: assert property ( // R13
		stopMode && !swBreak && state_ff == ABU_IDLE |=> state_ff == ABU_IDLE)
		else $error("break arose in stop mode");

	chk_disabled_gate: assert property ( // R07
		(!enable_ff && !swBreak && state_ff == ABU_IDLE) |=> state_ff == ABU_IDLE)
		else $error("address break while disabled");

	chk_addr_write: assert property ( // R17
		wrHigh |=> addrHigh_ff == $past(busWrData))
		else $error("address high byte not stored");

	cov_match_break: cover property (
		hwMatch ##[1:20] forceSwi_ff);
	cov_soft_break: cover property (
		swBreak ##[1:20] forceSwi_ff);
	cov_rti_return: cover property (
		state_ff == ABU_BREAK && rtiExec);
	cov_wait_wake: cover property (
		start && waitMode);

endmodule

// ---- abu_cpu_model.sv ----
/*
 * CPU stand-in for the address breakpoint unit: sequential two-cycle
 * instructions, then a short break routine after each forced SOFTWARE_INTERRUPT_OPCODE.
 * Assumes the unit and this model share clk and resetn.
 */
`timescale 1ns/1ps

module abu_cpu_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic run,
	input wire logic [15:0] startPc,
	input wire logic forceSwi_ff,
	output logic [15:0] cpuAddr,
	output logic cpuFetch,
	output logic instrLastCycle,
	output logic rtiExec
);
	logic [3:0] brkCnt_ff;

	// Fetch stops for the whole break routine, so no stale match
	assign cpuFetch = run && (brkCnt_ff == 4'h0);
	assign rtiExec = (brkCnt_ff == 4'h1);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cpuAddr <= 16'h0000;
			instrLastCycle <= 1'b0;
		end else if (!cpuFetch) begin
			cpuAddr <= startPc;
			instrLastCycle <= 1'b0;
		end else begin
			instrLastCycle <= !instrLastCycle;
			if (instrLastCycle) begin
				cpuAddr <= cpuAddr + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			brkCnt_ff <= 4'h0;
		end else if (forceSwi_ff) begin
			brkCnt_ff <= 4'hA;
		end else if (brkCnt_ff != 4'h0) begin
			brkCnt_ff <= brkCnt_ff - 4'h1;
		end
	end
endmodule

// ---- abu_defs.svh ----
/*
 * Register offsets, field positions, reset values and vectors of the
 * address breakpoint unit. Assumes a 16-bit internal address bus.
 */
`ifndef ABU_DEFS_SVH
`define ABU_DEFS_SVH

// ********************************
// Register map
// ********************************
`define ABU_STATUS_CONTROL_ADDR 16'hFE0B
`define ABU_ADDRESS_HIGH_ADDR 16'hFE0C
`define ABU_ADDRESS_LOW_ADDR 16'hFE0D

// ********************************
// Status/control fields
// ********************************
`define ABU_ENABLE_BIT 7
`define ABU_ACTIVE_BIT 6

// ********************************
// Reset values
// ********************************
`define ABU_ADDRESS_RESET 8'h00
`define ABU_READ_IDLE 8'h00

// ********************************
// Break vectors
// ********************************
`define ABU_USER_VECTOR 16'hFFFC
`define ABU_MONITOR_VECTOR 16'hFEFC

`endif

// ---- abu_pkg.sv ----
/*
 * Types of the address breakpoint unit.
 * Assumes abu_defs.svh is included by the design files.
 */
package abu_pkg;

	// Unit progress: idle, waiting for the instruction end, in break
	typedef enum logic [1:0] {
		ABU_IDLE,
		ABU_PEND,
		ABU_BREAK
	} abu_state_t;

endpackage

// ---- tb_address_breakpoint_unit.sv ----
/*
 * Self-checking bench for the address breakpoint unit.
 * Assumes abu_defs.svh, abu_pkg and abu_cpu_model are compiled first.
 */
`timescale 1ns/1ps
`include "abu_defs.svh"

module tb_address_breakpoint_unit;
	logic clk = 0, resetn = 0, busWr = 0, busRd = 0, run = 0;
	logic monitorMode = 0, waitMode = 0, stopMode = 0;
	logic highTestVoltage = 0, flagClearEnable = 0, waitBreakClear = 0;
	logic [15:0] busAddr = 16'h0000, startPc = 16'h1230, cpuAddr, vectorAddr_ff;
	logic [7:0] busWrData = 8'h00, busRdData_ff, rdv;
	logic cpuFetch, instrLastCycle, rtiExec, breakReq_ff, forceSwi_ff, seen;
	logic timerHalt_ff, watchdogDisable_ff, flagClearAllowed_ff, waitBreak_ff;
	int errors = 0, samples_checked = 0;

	always #5 clk = ~clk;

	abu_address_breakpoint_unit dut_u (.clk(clk), .resetn(resetn), .busAddr(busAddr),
		.busWrData(busWrData), .busWr(busWr), .busRd(busRd), .busRdData_ff(busRdData_ff),
		.cpuAddr(cpuAddr), .cpuFetch(cpuFetch), .instrLastCycle(instrLastCycle),
		.rtiExec(rtiExec), .monitorMode(monitorMode), .waitMode(waitMode),
		.stopMode(stopMode), .highTestVoltage(highTestVoltage),
		.flagClearEnable(flagClearEnable), .waitBreakClear(waitBreakClear),
		.breakReq_ff(breakReq_ff), .forceSwi_ff(forceSwi_ff), .vectorAddr_ff(vectorAddr_ff),
		.timerHalt_ff(timerHalt_ff), .watchdogDisable_ff(watchdogDisable_ff),
		.flagClearAllowed_ff(flagClearAllowed_ff), .waitBreak_ff(waitBreak_ff));

	abu_cpu_model cpu_u (.clk(clk), .resetn(resetn), .run(run), .startPc(startPc),
		.forceSwi_ff(forceSwi_ff), .cpuAddr(cpuAddr), .cpuFetch(cpuFetch),
		.instrLastCycle(instrLastCycle), .rtiExec(rtiExec));

	// ********************************
	// Shared tasks
	// ********************************
	task chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [15:0] a, input logic [7:0] d);
		busAddr = a;
		busWrData = d;
		busWr = 1;
		@(posedge clk) #1;
		busWr = 0;
		// Idle cycle keeps back-to-back strobes as separate pulses
		@(posedge clk) #1;
	endtask

	task rd(input logic [15:0] a, output logic [7:0] d);
		busAddr = a;
		busRd = 1;
		@(posedge clk) #1;
		busRd = 0;
		d = busRdData_ff;
		@(posedge clk) #1;
	endtask

	// Bounded wait for one cycle of forceSwi_ff
	task waitSwi(input int n);
		seen = 0;
		repeat (n) begin
			@(posedge clk) #1;
			if (forceSwi_ff === 1'b1) begin
				seen = 1;
				break;
			end
		end
		run = 0;
	endtask

	task waitRti();
		for (int i = 0; i < 20 && rtiExec !== 1'b1; i++) begin
			@(posedge clk) #1;
		end
		@(posedge clk) #1;
	endtask

	// ********************************
	// Scenarios
	// ********************************
	task t_reset();
		rd(`ABU_STATUS_CONTROL_ADDR, rdv); chk(rdv, 8'h00);
		rd(`ABU_ADDRESS_HIGH_ADDR, rdv); chk(rdv, 8'h00);
		rd(`ABU_ADDRESS_LOW_ADDR, rdv); chk(rdv, 8'h00);
		wr(16'hFE0A, 8'hFF);
		rd(16'hFE0A, rdv); chk(rdv, 8'h00);
		$display("test reset done");
	endtask

	task t_regs();
		wr(`ABU_ADDRESS_HIGH_ADDR, 8'h12);
		wr(`ABU_ADDRESS_LOW_ADDR, 8'h34);
		rd(`ABU_ADDRESS_HIGH_ADDR, rdv); chk(rdv, 8'h12);
		rd(`ABU_ADDRESS_LOW_ADDR, rdv); chk(rdv, 8'h34);
		$display("test regs done");
	endtask

	task t_hwbreak();
		highTestVoltage = 1;
		wr(`ABU_STATUS_CONTROL_ADDR, 8'h80);
		run = 1;
		waitSwi(30); chk(seen, 1'b1);
		rd(`ABU_STATUS_CONTROL_ADDR, rdv); chk(rdv, 8'hC0);
		chk(breakReq_ff, 1'b0);
		chk(vectorAddr_ff, 16'hFFFC);
		chk(timerHalt_ff, 1'b1);
		chk(watchdogDisable_ff, 1'b1);
		chk(flagClearAllowed_ff, 1'b0);
		waitRti();
		chk(timerHalt_ff, 1'b0);
		wr(`ABU_STATUS_CONTROL_ADDR, 8'h00);
		rd(`ABU_STATUS_CONTROL_ADDR, rdv); chk(rdv, 8'h00);
		highTestVoltage = 0;
		$display("test hardware break done");
	endtask

	// Enable lands while the CPU sits in the last cycle at the break address
	task t_lastcycle();
		run = 1;
		repeat (8) @(posedge clk) #1;
		wr(`ABU_STATUS_CONTROL_ADDR, 8'h80);
		chk(forceSwi_ff, 1'b1);
		chk(breakReq_ff, 1'b1);
		run = 0;
		waitRti();
		wr(`ABU_STATUS_CONTROL_ADDR, 8'h00);
		$display("test last cycle done");
	endtask

	task t_blocked();
		run = 1;
		waitSwi(30); chk(seen, 1'b0);
		wr(`ABU_STATUS_CONTROL_ADDR, 8'h80);
		stopMode = 1;
		run = 1;
		waitSwi(30); chk(seen, 1'b0);
		rd(`ABU_ADDRESS_LOW_ADDR, rdv); chk(rdv, 8'h34);
		stopMode = 0;
		wr(`ABU_STATUS_CONTROL_ADDR, 8'h00);
		$display("test blocked done");
	endtask

	task t_swbreak();
		monitorMode = 1;
		waitMode = 1;
		flagClearEnable = 1;
		wr(`ABU_STATUS_CONTROL_ADDR, 8'h40);
		chk(breakReq_ff, 1'b1);
		chk(forceSwi_ff, 1'b0);
		run = 1;
		waitSwi(10); chk(seen, 1'b1);
		@(posedge clk) #1;
		chk(vectorAddr_ff, 16'hFEFC);
		chk(flagClearAllowed_ff, 1'b1);
		chk(watchdogDisable_ff, 1'b0);
		waitRti();
		chk(waitBreak_ff, 1'b1);
		waitBreakClear = 1;
		@(posedge clk) #1;
		waitBreakClear = 0;
		@(posedge clk) #1;
		chk(waitBreak_ff, 1'b0);
		wr(`ABU_STATUS_CONTROL_ADDR, 8'h00);
		$display("test software break done");
	endtask

	task end_sim();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk);
		#1 resetn = 1;
		@(posedge clk) #1;
		t_reset();
		t_regs();
		t_hwbreak();
		t_lastcycle();
		t_blocked();
		t_swbreak();
		end_sim();
	end

	// About 170 cycles expected; 3000, over seventeen times that, is a hang
	initial begin
		#30000;
		errors++;
		end_sim();
	end
endmodule
